// file: verilog/cic_top.sv
// CPU interrupt controller: flags, enables, entry sequence, shadows, APB
//
// Contract
// (RULE_01) Any reset leaves interrupts disabled
// (RULE_02) Peripheral redirect needs global, peripheral, source enable
// (RULE_03) Flags set regardless of any enable
// (RULE_04) Entry flushes prefetch and clears global enable
// (RULE_05) Entry pushes current pc onto stack
// (RULE_06) Entry loads pc with vector 0004h
// (RULE_07) Entry copies core context into shadows
// (RULE_08) Shadow status omits watchdog and powerdown bits
// (RULE_09) Global enable clear: flag only, no redirect
// (RULE_10) Pending flag taken when global enable returns
// (RULE_11) Return pops stack, restores shadows, sets enable
// (RULE_12) Firmware clears serviced flags before return
// (RULE_13) Requests sampled in first phase of cycle
// (RULE_14) Latency depends on executing instruction
// (RULE_15) Firmware enables wake source before sleep
// (RULE_16) Wake vectors only if global enable set
// (RULE_17) Instruction after sleep executes before vector
// (RULE_18) External pin gives edge request, enable bit
// (RULE_19) Edge polarity bit selects rising or falling
// (RULE_20) External edge sets flag, redirects when enabled
// (RULE_21) Return overwrites context from possibly altered shadows
// (RULE_22) Shadows readable and writable by software
// (RULE_23) Request is OR of enabled gated flags
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps
module cic_top
  import cic_pkg::*;
(
  input  wire logic             pclk,          // System clock
  input  wire logic             presetn,       // Async reset, active low
  input  wire logic             psel,          // APB select
  input  wire logic             penable,       // APB enable
  input  wire logic             pwrite,        // APB direction
  input  wire logic [7:0]       paddr,         // APB byte address
  input  wire logic [31:0]      pwdata,        // APB write data
  output logic                  pready,        // APB ready
  output logic [31:0]           prdata,        // APB read data
  output logic                  pslverr,       // APB error
  input  wire logic [7:0]       periph_evt0,   // Source events, reg 0
  input  wire logic [7:0]       periph_evt1,   // Source events, reg 1
  input  wire logic [7:0]       periph_evt2,   // Source events, reg 2
  input  wire logic             ext_request_pin, // External request pin
  input  wire logic             cyc_phase1,    // Core first_clock_phase strobe
  input  wire logic             instr_done,    // Core: current instruction ends
  input  wire logic             return_from_interrupt_exec,   // Core executes return
  input  wire logic             asleep,        // Core is in sleep
  input  wire cic_ctx_t         core_ctx,      // Core live context
  input  wire logic [14:0]      core_pc,       // Core current pc
  output cic_cmd_t              core_cmd,      // Commands to core
  output cic_ctx_t              shadow_out,    // Shadow context to restore
  output logic                  wake_req       // Wake pulse to sleep logic
);

  // Registers
  logic [7:0]  ctrl_ff;      // Control register
  logic [7:0]  en0_ff;       // Enable register 0
  logic [7:0]  en1_ff;       // Enable register 1
  logic [7:0]  en2_ff;       // Enable register 2
  logic [7:0]  flag0_ff;     // Flag register 0
  logic [7:0]  flag1_ff;     // Flag register 1
  logic [7:0]  flag2_ff;     // Flag register 2
  cic_ctx_t    shadow_ff;    // Shadow context
  cic_state_t  state_ff;     // Controller state
  cic_state_t  nxt_state;    // Next state
  logic        pin_d_ff;     // Previous pin level
  logic        pin_seen_ff;  // Pin history valid after reset
  logic        req_ff;       // Request latched at first phase
  logic        wake_ff;      // Wake pulse register
  logic        wake_vec_ff;  // Vector pending after wake instruction
  logic        ready_ff;     // APB ready register
  logic [31:0] rdata_ff;     // APB read data register
  logic        err_ff;       // APB error register
  cic_cmd_t    cmd_ff;       // Command register

  // Decoded strobes and combinational terms
  logic        apb_wr;       // Write access phase
  logic        apb_rd;       // Read access phase
  logic        ext_edge;     // Selected external edge
  logic        any_pending;  // Enabled flag pending, ignoring global
  logic        irq_req;      // Request to core
  logic        entry;        // Entry taken this cycle
  logic        mapped;       // Address decodes to register

  // Byte write helper: returns new value for a written byte
  function automatic logic [7:0] wbyte(input logic [7:0] old, input logic [31:0] d,
                                      input logic [7:0] mask);
    wbyte = (old & ~mask) | (d[7:0] & mask);
  endfunction : wbyte

  // Address hit helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // APB strobes; zero wait states
  assign apb_wr = psel && penable && pwrite && ready_ff;
  assign apb_rd = psel && penable && !pwrite && ready_ff;

  // Address decode
  // Unmapped addresses answer with an error and read as zero
  always_comb begin
    case (paddr)
      CIC_ADDR_CTRL, CIC_ADDR_EN0, CIC_ADDR_EN1, CIC_ADDR_EN2,
      CIC_ADDR_FLAG0, CIC_ADDR_FLAG1, CIC_ADDR_FLAG2, CIC_ADDR_SH_W,
      CIC_ADDR_SH_ST, CIC_ADDR_SH_BSR, CIC_ADDR_SH_FSR, CIC_ADDR_SH_PCH,
      CIC_ADDR_STATE: mapped = 1'b1;
      default:        mapped = 1'b0;
    endcase
  end

  // External pin edge detect, polarity selectable; no edge before history
  assign ext_edge = pin_seen_ff &&
                    (ctrl_ff[CIC_CTRL_EDGE_BIT] ? (ext_request_pin && !pin_d_ff)    // RULE_19
                                                : (!ext_request_pin && pin_d_ff));  // RULE_18

  // Peripheral bits of register 0: implemented bits less the pin bit
  localparam logic [7:0] PERIPH0_MASK = CIC_EN0_MASK & ~(8'h01 << CIC_EN0_EXT_BIT);

  // Pending: ext pin gated by own enable; peripherals also by peripheral enable
  assign any_pending = (flag0_ff[CIC_EN0_EXT_BIT] && en0_ff[CIC_EN0_EXT_BIT]) ||   // RULE_20
                       (ctrl_ff[CIC_CTRL_PERIPHERAL_IRQ_ENABLE_BIT] &&                              // RULE_02
                        (|(flag0_ff & en0_ff & PERIPH0_MASK)
                         || |(flag1_ff & en1_ff) || |(flag2_ff & en2_ff)));       // RULE_23
  // A flag left pending requests again as soon as global enable returns
  assign irq_req = any_pending && ctrl_ff[CIC_CTRL_GIE_BIT];                       // RULE_09

  // Entry when request sampled and current instruction ends
  // Live request gates too: no entry in the cycle after global enable drops
  assign entry = (state_ff == CIC_IDLE) && req_ff && instr_done && !asleep &&      // RULE_14
                 irq_req;                                                          // RULE_10

  // Previous pin level; history marked valid one edge after reset
  // Without the valid bit a pin idling high would look like a rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d_ff    <= 1'b0;
      pin_seen_ff <= 1'b0;
    end else begin
      pin_d_ff    <= ext_request_pin;
      pin_seen_ff <= 1'b1;
    end
  end

  // Request sampled in first phase; held until entry
  // Cleared whenever the request drops, so a stale request never fires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff <= 1'b0;
    end else if (entry || !irq_req) begin
      req_ff <= 1'b0;
    end else if (cyc_phase1 && !wake_vec_ff) begin
      req_ff <= 1'b1;                                                              // RULE_13
    end
  end

  // Control register: global enable cleared on entry, set on return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CIC_CTRL_RST;                                                     // RULE_01
    end else begin
      if (apb_wr && hit(paddr, CIC_ADDR_CTRL)) begin
        ctrl_ff <= wbyte(ctrl_ff, pwdata, 8'hC1);
      end
      if (entry) begin
        ctrl_ff[CIC_CTRL_GIE_BIT] <= 1'b0;                                         // RULE_04
      end else if (return_from_interrupt_exec && state_ff == CIC_SERVICE) begin
        ctrl_ff[CIC_CTRL_GIE_BIT] <= 1'b1;                                         // RULE_11
      end
    end
  end

  // Enable registers
  // Only implemented bits of register 0 take writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en0_ff <= CIC_BYTE_ZERO;
      en1_ff <= CIC_BYTE_ZERO;
      en2_ff <= CIC_BYTE_ZERO;
    end else if (apb_wr) begin
      if (hit(paddr, CIC_ADDR_EN0)) en0_ff <= wbyte(en0_ff, pwdata, CIC_EN0_MASK);
      if (hit(paddr, CIC_ADDR_EN1)) en1_ff <= pwdata[7:0];
      if (hit(paddr, CIC_ADDR_EN2)) en2_ff <= pwdata[7:0];
    end
  end

  // Flags: events set regardless of enables; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag0_ff <= CIC_BYTE_ZERO;
      flag1_ff <= CIC_BYTE_ZERO;
      flag2_ff <= CIC_BYTE_ZERO;
    end else begin
      // Software writes first, then hardware sets on top (RULE_12 by firmware)
      flag0_ff <= (apb_wr && hit(paddr, CIC_ADDR_FLAG0) ? pwdata[7:0] & CIC_EN0_MASK
                                                        : flag0_ff)
                  | (periph_evt0 & CIC_EN0_MASK & ~8'h01)
                  | {7'h00, ext_edge};                                             // RULE_03
      flag1_ff <= (apb_wr && hit(paddr, CIC_ADDR_FLAG1) ? pwdata[7:0] : flag1_ff)
                  | periph_evt1;                                                   // RULE_03
      flag2_ff <= (apb_wr && hit(paddr, CIC_ADDR_FLAG2) ? pwdata[7:0] : flag2_ff)
                  | periph_evt2;                                                   // RULE_03
    end
  end

  // Shadows: captured on entry, else software access
  // Entry capture wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_ff <= '0;
    end else if (entry) begin
      shadow_ff        <= core_ctx;                                                // RULE_07
      shadow_ff.status <= core_ctx.status & CIC_STATUS_KEEP_MASK;                  // RULE_08
    end else if (apb_wr) begin
      if (hit(paddr, CIC_ADDR_SH_W))   shadow_ff.w   <= pwdata[7:0];               // RULE_22
      if (hit(paddr, CIC_ADDR_SH_ST))
        shadow_ff.status <= pwdata[7:0] & CIC_STATUS_KEEP_MASK;
      if (hit(paddr, CIC_ADDR_SH_BSR)) shadow_ff.bank_select_register <= pwdata[7:0];
      if (hit(paddr, CIC_ADDR_SH_FSR)) shadow_ff.file_select_register <= pwdata[15:0];
      if (hit(paddr, CIC_ADDR_SH_PCH)) shadow_ff.pch <= pwdata[7:0];
    end
  end

  // Wake: enabled source wakes sleep; vector only after next instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_ff     <= 1'b0;
      wake_vec_ff <= 1'b0;
    end else begin
      // One pulse per wake: the pending vector flag blocks repeats while asleep
      wake_ff <= asleep && any_pending && !wake_ff && !wake_vec_ff;                // RULE_16
      if (wake_ff) begin
        wake_vec_ff <= 1'b1;                                                       // RULE_17
      end else if (instr_done) begin
        wake_vec_ff <= 1'b0;
      end
    end
  end

  // Entry sequence state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CIC_IDLE:    if (entry) nxt_state = CIC_FLUSH;
      CIC_FLUSH:   nxt_state = CIC_PUSH;
      CIC_PUSH:    nxt_state = CIC_LOADVEC;
      CIC_LOADVEC: nxt_state = CIC_SERVICE;
      CIC_SERVICE: if (return_from_interrupt_exec) nxt_state = CIC_IDLE;
      default:     nxt_state = CIC_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= CIC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Commands to core, one cycle each
  // Pc carries the vector only while load_pc is up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff <= '0;
    end else begin
      cmd_ff.flush   <= entry;                                                     // RULE_04
      cmd_ff.push    <= (state_ff == CIC_FLUSH);                                   // RULE_05
      cmd_ff.load_pc <= (state_ff == CIC_PUSH);                                    // RULE_06
      cmd_ff.pc      <= (state_ff == CIC_PUSH) ? CIC_VECTOR : core_pc;
      cmd_ff.pop     <= return_from_interrupt_exec && (state_ff == CIC_SERVICE);                  // RULE_11
      cmd_ff.restore <= return_from_interrupt_exec && (state_ff == CIC_SERVICE);                  // RULE_21
    end
  end

  // APB slave: zero wait, error on unmapped
  // Read data staged in setup so it stands for the whole access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_ff <= 1'b1;
      rdata_ff <= CIC_WORD_ZERO;
      err_ff   <= 1'b0;
    end else begin
      ready_ff <= 1'b1;
      err_ff   <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          CIC_ADDR_CTRL:   rdata_ff <= {24'h000000, ctrl_ff};
          CIC_ADDR_EN0:    rdata_ff <= {24'h000000, en0_ff};
          CIC_ADDR_EN1:    rdata_ff <= {24'h000000, en1_ff};
          CIC_ADDR_EN2:    rdata_ff <= {24'h000000, en2_ff};
          CIC_ADDR_FLAG0:  rdata_ff <= {24'h000000, flag0_ff};
          CIC_ADDR_FLAG1:  rdata_ff <= {24'h000000, flag1_ff};
          CIC_ADDR_FLAG2:  rdata_ff <= {24'h000000, flag2_ff};
          CIC_ADDR_SH_W:   rdata_ff <= {24'h000000, shadow_ff.w};                  // RULE_22
          CIC_ADDR_SH_ST:  rdata_ff <= {24'h000000, shadow_ff.status};
          CIC_ADDR_SH_BSR: rdata_ff <= {24'h000000, shadow_ff.bank_select_register};
          CIC_ADDR_SH_FSR: rdata_ff <= {16'h0000, shadow_ff.file_select_register};
          CIC_ADDR_SH_PCH: rdata_ff <= {24'h000000, shadow_ff.pch};
          CIC_ADDR_STATE:  rdata_ff <= {28'h0000000, req_ff, state_ff};
          default:         rdata_ff <= CIC_WORD_ZERO;
        endcase
      end
    end
  end

  // Outputs straight from flip-flops
  assign pready     = ready_ff;
  assign prdata     = rdata_ff;
  assign pslverr    = err_ff;
  assign core_cmd   = cmd_ff;
  assign shadow_out = shadow_ff;
  assign wake_req   = wake_ff;

  // Checks on the entry and return sequence and the external flag, off during reset
  a_flush_clears_gie: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    cmd_ff.flush |-> !ctrl_ff[CIC_CTRL_GIE_BIT])
    else $error("global enable not cleared on entry");
  a_push_after_flush: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    cmd_ff.flush |=> cmd_ff.push ##1 (cmd_ff.load_pc && cmd_ff.pc == CIC_VECTOR))
    else $error("entry sequence wrong");
  a_vector_value: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    cmd_ff.load_pc |-> cmd_ff.pc == CIC_VECTOR)
    else $error("wrong vector");
  a_no_entry_gie: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    !ctrl_ff[CIC_CTRL_GIE_BIT] |=> !cmd_ff.flush)
    else $error("entry while disabled");
  a_shadow_status: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
    cmd_ff.flush |-> (shadow_ff.status & ~CIC_STATUS_KEEP_MASK) == CIC_BYTE_ZERO)
    else $error("status shadow holds excluded bits");
  a_ctx_capture: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    entry |=> shadow_ff.w == $past(core_ctx.w) && shadow_ff.file_select_register == $past(core_ctx.file_select_register))
    else $error("context not captured");
  a_return_sets_gie: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    cmd_ff.restore |-> ctrl_ff[CIC_CTRL_GIE_BIT] && cmd_ff.pop)
    else $error("return did not set global enable");
  a_ext_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
    ext_edge |=> flag0_ff[CIC_EN0_EXT_BIT])
    else $error("external flag not set");

endmodule : cic_top

// file: verilog/cic_pkg.sv
// Package for the CPU interrupt controller: register map, fields, types
package cic_pkg;

  // APB word offsets (byte addresses)
  localparam logic [7:0] CIC_ADDR_CTRL    = 8'h00; // irq_control_register
  localparam logic [7:0] CIC_ADDR_EN0     = 8'h04; // enable_register_0
  localparam logic [7:0] CIC_ADDR_EN1     = 8'h08; // enable register 1
  localparam logic [7:0] CIC_ADDR_EN2     = 8'h0C; // enable register 2
  localparam logic [7:0] CIC_ADDR_FLAG0   = 8'h10; // flag_register_0
  localparam logic [7:0] CIC_ADDR_FLAG1   = 8'h14; // flag_register_1
  localparam logic [7:0] CIC_ADDR_FLAG2   = 8'h18; // flag_register_2
  localparam logic [7:0] CIC_ADDR_SH_W    = 8'h20; // Shadow working register
  localparam logic [7:0] CIC_ADDR_SH_ST   = 8'h24; // Shadow status
  localparam logic [7:0] CIC_ADDR_SH_BSR  = 8'h28; // Shadow bank select
  localparam logic [7:0] CIC_ADDR_SH_FSR  = 8'h2C; // Shadow file select (16 bit)
  localparam logic [7:0] CIC_ADDR_SH_PCH  = 8'h30; // Shadow pc high latch
  localparam logic [7:0] CIC_ADDR_STATE   = 8'h34; // Controller state readback

  // Control register and register 0 fields
  localparam int CIC_CTRL_GIE_BIT  = 7; // global_irq_enable
  localparam int CIC_CTRL_PERIPHERAL_IRQ_ENABLE_BIT = 6; // peripheral_irq_enable
  localparam int CIC_CTRL_EDGE_BIT = 0; // ext_edge_polarity
  localparam int CIC_EN0_EXT_BIT   = 0; // ext_pin_irq_enable / ext_pin_irq_flag
  localparam logic [7:0] CIC_EN0_MASK = 8'h31; // Implemented bits of reg 0

  // Status bits excluded from the shadow (watchdog expiry, powerdown)
  localparam logic [7:0] CIC_STATUS_KEEP_MASK = 8'hE7;

  // Reset values and the entry vector
  localparam logic [7:0]  CIC_CTRL_RST   = 8'h01;
  localparam logic [14:0] CIC_VECTOR     = 15'h0004;
  localparam logic [7:0]  CIC_BYTE_ZERO  = 8'h00;
  localparam logic [31:0] CIC_WORD_ZERO  = 32'h0000_0000;
  localparam logic [14:0] CIC_PC_ZERO    = 15'h0000;
  localparam logic [15:0] CIC_FSR_ZERO   = 16'h0000;

  // Controller states, Gray along idle->flush->push->vector->service
  typedef enum logic [2:0] {
    CIC_IDLE    = 3'b000,
    CIC_FLUSH   = 3'b001,
    CIC_PUSH    = 3'b011,
    CIC_LOADVEC = 3'b010,
    CIC_SERVICE = 3'b110,
    CIC_WAKE    = 3'b111
  } cic_state_t;

  // Core context carried between core and shadows
  typedef struct packed {
    logic [7:0]  w;      // Working register
    logic [7:0]  status; // Status register
    logic [7:0]  bank_select_register;    // bank_select_register
    logic [15:0] file_select_register;    // file_select_register
    logic [7:0]  pch;    // pc_high_latch
  } cic_ctx_t;

  // Commands to the core sequencer
  typedef struct packed {
    logic        flush;    // Discard prefetched instruction
    logic        push;     // Push return pc onto stack
    logic        pop;      // Pop return pc
    logic        load_pc;  // Load pc with vector
    logic        restore;  // Core loads context from shadow
    logic [14:0] pc;       // Pc value to load
  } cic_cmd_t;

endpackage : cic_pkg

// file: bench/cic_core_model.sv
// Core sequencer model: phase strobes, program counter, return stack
`timescale 1ns/10ps
module cic_core_model
  import cic_pkg::*;
(
  input  wire logic     pclk,       // System clock
  input  wire logic     presetn,    // Async reset, active low
  input  wire logic     slow,       // Two-cycle instructions
  input  wire logic     asleep,     // Core halted in sleep
  input  wire cic_cmd_t core_cmd,   // Commands from controller
  output logic          cyc_phase1, // First phase strobe
  output logic          instr_done, // Instruction end strobe
  output logic [14:0]   core_pc     // Current pc
);
  logic [2:0]  ph_ff;         // Phase counter
  logic [3:0]  sp_ff;         // Stack pointer
  logic [14:0] stk [0:15];    // Return stack
  // Strobes stop while asleep; slow mode doubles the cycle
  assign cyc_phase1 = presetn && !asleep && ph_ff == 3'h0;
  assign instr_done = presetn && !asleep && ph_ff == (slow ? 3'h7 : 3'h3);
  // Phase counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_ff <= 3'h0;
    end else if (!asleep) begin
      ph_ff <= instr_done ? 3'h0 : ph_ff + 3'h1;
    end
  end
  // Pc and stack follow the controller commands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_pc <= 15'h0000;
      sp_ff <= 4'h0;
    end else if (core_cmd.push) begin
      stk[sp_ff] <= core_pc;
      sp_ff <= sp_ff + 4'h1;
    end else if (core_cmd.pop) begin
      core_pc <= stk[sp_ff - 4'h1];
      sp_ff <= sp_ff - 4'h1;
    end else if (core_cmd.load_pc) begin
      core_pc <= core_cmd.pc;
    end else if (instr_done) begin
      core_pc <= core_pc + 15'h0001;
    end
  end
endmodule : cic_core_model

// file: bench/tb.sv
// Self-checking testbench for the interrupt controller
`timescale 1ns/10ps
module tb;
  import cic_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, periph_evt0, periph_evt1, periph_evt2;
  logic [31:0] pwdata, prdata;
  logic        ext_request_pin, cyc_phase1, instr_done, return_from_interrupt_exec;
  logic        asleep, wake_req, slow;
  logic [14:0] core_pc, load_pc;
  cic_ctx_t    core_ctx, shadow_out, rest_ctx;
  cic_cmd_t    core_cmd;
  int err_count, n_tests, n_flush, n_push, n_pop, n_wake, n_done, d_at_flush, f;
  cic_top        cic_top_inst (.*);
  cic_core_model cic_core_model_inst (.*);
  always #2 pclk = ~pclk;
  // Tally controller pulses at each edge
  always @(posedge pclk) begin
    if (instr_done) n_done++;
    if (wake_req) n_wake++;
    if (core_cmd.push) n_push++;
    if (core_cmd.pop) n_pop++;
    if (core_cmd.load_pc) load_pc = core_cmd.pc;
    if (core_cmd.restore) rest_ctx = shadow_out;
    if (core_cmd.flush) begin
      n_flush++;
      d_at_flush = n_done;
    end
  end
  task automatic end_of_test();
    $display("errors %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for ready; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  // One-cycle source event pulses
  task automatic fire(input logic [7:0] m0, input logic [7:0] m1, input logic [7:0] m2);
    @(posedge pclk);
    periph_evt0 <= m0;
    periph_evt1 <= m1;
    periph_evt2 <= m2;
    @(posedge pclk);
    {periph_evt0, periph_evt1, periph_evt2} <= 24'h00_0000;
  endtask : fire
  task automatic ret();
    @(posedge pclk);
    return_from_interrupt_exec <= 1'b1;
    @(posedge pclk);
    return_from_interrupt_exec <= 1'b0;
  endtask : ret
  task automatic t_reset_flag();
    logic [31:0] r;
    logic e;
    rd(CIC_ADDR_CTRL, 32'h0000_0001);
    rd(CIC_ADDR_FLAG0, 32'h0000_0000);
    apb(1'b0, 8'h3C, 32'h0000_0000, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    f = n_flush;
    fire(8'h00, 8'h04, 8'h00);
    idle(30);
    rd(CIC_ADDR_FLAG1, 32'h0000_0004);
    chk(n_flush, f);
    wr(CIC_ADDR_FLAG1, 32'h0000_0000);
  endtask : t_reset_flag
  task automatic t_entry_return();
    wr(CIC_ADDR_EN1, 32'h0000_0004);
    wr(CIC_ADDR_CTRL, 32'h0000_0081);
    f = n_flush;
    fire(8'h00, 8'h04, 8'h00);
    idle(40);
    chk(n_flush, f);
    wr(CIC_ADDR_CTRL, 32'h0000_00C1);
    idle(40);
    chk(n_flush, f + 1);
    chk(n_push, 1);
    chk(load_pc, CIC_VECTOR);
    rd(CIC_ADDR_CTRL, 32'h0000_0041);
    rd(CIC_ADDR_SH_ST, 32'h0000_00E7);
    rd(CIC_ADDR_SH_FSR, 32'h0000_3344);
    core_ctx.w <= 8'h99;
    wr(CIC_ADDR_SH_W, 32'h0000_005A);
    rd(CIC_ADDR_SH_W, 32'h0000_005A);
    wr(CIC_ADDR_FLAG1, 32'h0000_0000);
    fire(8'h00, 8'h04, 8'h00);
    idle(30);
    chk(n_flush, f + 1);
    ret();
    idle(3);
    chk(n_pop, 1);
    chk(rest_ctx.w, 8'h5A);
    idle(40);
    chk(n_flush, f + 2);
    wr(CIC_ADDR_FLAG1, 32'h0000_0000);
    ret();
    idle(30);
    rd(CIC_ADDR_CTRL, 32'h0000_00C1);
    chk(n_flush, f + 2);
    wr(CIC_ADDR_CTRL, 32'h0000_0001);
  endtask : t_entry_return
  task automatic t_ext_pin();
    wr(CIC_ADDR_EN0, 32'h0000_0001);
    @(posedge pclk) ext_request_pin <= 1'b0;
    idle(4);
    rd(CIC_ADDR_FLAG0, 32'h0000_0000);
    @(posedge pclk) ext_request_pin <= 1'b1;
    idle(4);
    rd(CIC_ADDR_FLAG0, 32'h0000_0001);
    wr(CIC_ADDR_FLAG0, 32'h0000_0000);
    wr(CIC_ADDR_CTRL, 32'h0000_0000);
    @(posedge pclk) ext_request_pin <= 1'b0;
    idle(4);
    rd(CIC_ADDR_FLAG0, 32'h0000_0001);
    slow <= 1'b1;
    f = n_flush;
    wr(CIC_ADDR_CTRL, 32'h0000_0080);
    idle(60);
    chk(n_flush, f + 1);
    wr(CIC_ADDR_FLAG0, 32'h0000_0000);
    ret();
    slow <= 1'b0;
    wr(CIC_ADDR_CTRL, 32'h0000_0001);
  endtask : t_ext_pin
  task automatic t_sleep();
    int w, d;
    wr(CIC_ADDR_EN2, 32'h0000_0001);
    wr(CIC_ADDR_CTRL, 32'h0000_0041);
    w = n_wake;
    f = n_flush;
    asleep <= 1'b1;
    fire(8'h00, 8'h00, 8'h01);
    idle(10);
    chk(n_wake, w + 1);
    asleep <= 1'b0;
    idle(30);
    chk(n_flush, f);
    wr(CIC_ADDR_FLAG2, 32'h0000_0000);
    asleep <= 1'b1;
    wr(CIC_ADDR_CTRL, 32'h0000_00C1);
    fire(8'h00, 8'h00, 8'h01);
    idle(10);
    d = n_done;
    asleep <= 1'b0;
    idle(30);
    chk(n_flush, f + 1);
    chk(d_at_flush > d, 1);
  endtask : t_sleep
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    end_of_test();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, return_from_interrupt_exec, asleep, slow} = 8'h00;
    {paddr, periph_evt0, periph_evt1, periph_evt2} = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    ext_request_pin = 1'b1;
    core_ctx = {8'h11, 8'hFF, 8'h22, 16'h3344, 8'h55};
    idle(2);
    presetn <= 1'b1;
    t_reset_flag();
    t_entry_return();
    t_ext_pin();
    t_sleep();
    end_of_test();
  end
endmodule : tb
